// *** hdl/flash_cmd_cfg.svh ***
// Purpose: constants of the flash command state machine
// Assumes: byte-wide Wishbone slave, 40 MHz clock
// Notes: command codes seed the module parameters and are written directly by the test
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH
// bus address map (byte addresses)
`define ARRAY_LAST 8'h3f
`define LOCK_BASE 8'h80
`define LOCK_LAST 8'h83
`define ID_MAKER_ADDR 6'h00
`define ID_PART_ADDR 6'h01
`define ID_MAKER_CODE 8'h5a
`define ID_PART_CODE 8'h3c
`define TOP_BLOCK 2'h3
`define BLOCK_LAST_IDX 4'hf
// status byte bit positions
`define SR_READY 7
`define SR_ESUSP 6
`define SR_EERR 5
`define SR_PERR 4
`define SR_PSUSP 2
`define SR_LOCK 1
// lock register
`define LOCK_WL_BIT 0
`define LOCK_RESET 1'b1
`define ERASED_BYTE 8'hff
// timing
`define CLK_PERIOD_NS 25
`define ERASE_STEP_NS 100
`define ERASE_STEP_CYC ((`ERASE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_TIME_NS 400
`define PROG_CYC ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_CHECK_CYC 4
// command codes
`define CMD_READ_ARRAY 8'hff
`define CMD_READ_ID 8'h90
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_ERASE_SETUP 8'h20
`define CMD_CONFIRM 8'hd0
`define CMD_PROG_SETUP 8'h40
`define CMD_SUSPEND 8'hb0
`endif

// *** hdl/flash_cmd_pkg.sv ***
// Purpose: types of the flash command state machine
// Assumes: nothing
// Notes: constants live in flash_cmd_cfg.svh
package flash_cmd_pkg;
    // command_front_end read modes
    typedef enum logic [2:0] {
        M_ARRAY, M_ID, M_STATUS, M_ERASE_SETUP, M_PROG_SETUP
    } mode_t;
    // write_sequencer states
    typedef enum logic [2:0] {
        S_IDLE, S_ERASE, S_ERASE_SUSP, S_PROG, S_PROG_SUSP, S_ESUSP_PROG
    } seq_t;
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
    } prog_op_t;
    typedef struct packed {
        logic eraseError;
        logic programError;
        logic lockAbort;
    } err_flags_t;
endpackage

// *** hdl/flash_command_state_machine.sv ***
// Purpose: command front end and write sequencer of a byte flash
// Assumes: classic Wishbone, 8-bit data, one clock
// Notes: array is a small on-chip model of 4 blocks of 16 bytes
`timescale 1ns/100ps
`include "flash_cmd_cfg.svh"
module flash_command_state_machine
    import flash_cmd_pkg::*;
#(
    parameter logic [7:0] CMD_READ_ARRAY = `CMD_READ_ARRAY,
    parameter logic [7:0] CMD_READ_ID = `CMD_READ_ID,
    parameter logic [7:0] CMD_READ_STATUS = `CMD_READ_STATUS,
    parameter logic [7:0] CMD_CLEAR_STATUS = `CMD_CLEAR_STATUS,
    parameter logic [7:0] CMD_ERASE_SETUP = `CMD_ERASE_SETUP,
    parameter logic [7:0] CMD_CONFIRM = `CMD_CONFIRM,
    parameter logic [7:0] CMD_PROG_SETUP = `CMD_PROG_SETUP,
    parameter logic [7:0] CMD_SUSPEND = `CMD_SUSPEND,
    parameter logic [7:0] MAKER_CODE = `ID_MAKER_CODE, // value is arbitrary
    parameter logic [7:0] PART_CODE = `ID_PART_CODE // value is arbitrary
) (
    input wire logic clk, // 40 MHz clock
    input wire logic rst_n, // async reset, active low
    input wire logic initN, // processor init pin, active low
    input wire logic topBlockProtectN, // top block protect pin, active low
    input wire logic writeProtectN, // other blocks protect pin, active low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic wb_sel_i, // byte select
    input wire logic [7:0] wb_dat_i, // write data
    output logic [7:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    output logic sequencerReadyFlag // write_sequencer idle or suspended
);
    // ******************************
    // pins and storage
    // ******************************
    logic [2:0] sync1, sync2, sync3, pinLevel, next_pinLevel;
    logic initLevel, topProtLevel, wpLevel;
    logic [7:0] mem [64];
    logic memWe;
    logic [5:0] memAddr;
    logic [7:0] memData;

    mode_t mode, next_mode;
    seq_t state, next_state;
    prog_op_t op, next_op;
    err_flags_t errs, next_errs;
    logic [1:0] eraseBlk, next_eraseBlk;
    logic [3:0] eraseIdx, next_eraseIdx;
    logic [7:0] eraseCnt, next_eraseCnt;
    logic [7:0] progCnt, next_progCnt;
    logic eraseSuspReq, next_eraseSuspReq;
    logic progSuspReq, next_progSuspReq;
    logic resumePending, next_resumePending;
    logic [3:0] lockBit, next_lockBit;
    logic ack, next_ack;
    logic [7:0] datO, next_datO;

    logic take, inArray, inLock, running, cmdWrite;
    logic [7:0] status, oldByte;

    function automatic logic blockLocked(input logic [1:0] blk, input logic [3:0] wl,
                                         input logic topProt, input logic wp);
        blockLocked = wl[blk] | ((blk == `TOP_BLOCK) ? !topProt : !wp);
    endfunction

    // ******************************
    // pin synchronisers
    // ******************************
    // level accepted only once second and third stage agree
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            next_pinLevel[i] = (sync2[i] == sync3[i]) ? sync3[i] : pinLevel[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
            sync3 <= 3'h7;
            pinLevel <= 3'h7;
        end else begin
            sync1 <= {writeProtectN, topBlockProtectN, initN};
            sync2 <= sync1;
            sync3 <= sync2;
            pinLevel <= next_pinLevel;
        end
    end

    assign initLevel = pinLevel[0];
    assign topProtLevel = pinLevel[1];
    assign wpLevel = pinLevel[2];

    // ******************************
    // decode and status
    // ******************************
    assign take = wb_cyc_i && wb_stb_i && !ack;
    assign inArray = wb_adr_i <= `ARRAY_LAST;
    assign inLock = (wb_adr_i >= `LOCK_BASE) && (wb_adr_i <= `LOCK_LAST);
    assign cmdWrite = take && wb_we_i && wb_sel_i && inArray;
    assign running = (state == S_ERASE) || (state == S_PROG) || (state == S_ESUSP_PROG);
    assign oldByte = mem[op.addr];

    always_comb begin
        status = 8'h00;
        status[`SR_READY] = !running;
        status[`SR_ESUSP] = (state == S_ERASE_SUSP) || (state == S_ESUSP_PROG);
        status[`SR_PSUSP] = state == S_PROG_SUSP;
        status[`SR_EERR] = errs.eraseError;
        status[`SR_PERR] = errs.programError;
        status[`SR_LOCK] = errs.lockAbort;
    end

    // ******************************
    // front end and sequencer
    // ******************************
    always_comb begin
        next_mode = mode;
        next_state = state;
        next_op = op;
        next_errs = errs;
        next_eraseBlk = eraseBlk;
        next_eraseIdx = eraseIdx;
        next_eraseCnt = eraseCnt;
        next_progCnt = progCnt;
        next_eraseSuspReq = eraseSuspReq;
        next_progSuspReq = progSuspReq;
        next_resumePending = resumePending;
        next_lockBit = lockBit;
        next_ack = take;
        next_datO = datO;
        memWe = 1'b0;
        memAddr = op.addr;
        memData = oldByte & op.data;

        // sequencer progress
        unique case (state)
            S_ERASE: begin
                // suspend only at a step boundary
                if (eraseCnt == 8'h00 && eraseSuspReq) begin
                    next_state = S_ERASE_SUSP;
                    next_eraseSuspReq = 1'b0;
                end else if (eraseCnt == 8'(`ERASE_STEP_CYC - 1)) begin
                    memWe = 1'b1;
                    memAddr = {eraseBlk, eraseIdx};
                    memData = `ERASED_BYTE;
                    next_eraseCnt = 8'h00;
                    next_eraseIdx = eraseIdx + 4'h1;
                    if (eraseIdx == `BLOCK_LAST_IDX) begin
                        next_state = S_IDLE;
                    end
                end else begin
                    next_eraseCnt = eraseCnt + 8'h01;
                end
            end
            S_PROG, S_ESUSP_PROG: begin
                if (state == S_PROG && progSuspReq && progCnt % 8'(`PROG_CHECK_CYC) == 8'h00) begin
                    next_state = S_PROG_SUSP;
                    next_progSuspReq = 1'b0;
                end else if (progCnt == 8'(`PROG_CYC - 1)) begin
                    memWe = 1'b1;
                    // only ones that failed to clear count as error
                    if (|(oldByte & ~op.data & memData)) begin
                        next_errs.programError = 1'b1;
                    end
                    next_progCnt = 8'h00;
                    if (state == S_PROG) begin
                        next_state = S_IDLE;
                    end else begin
                        next_state = resumePending ? S_ERASE : S_ERASE_SUSP;
                        next_resumePending = 1'b0;
                    end
                end else begin
                    next_progCnt = progCnt + 8'h01;
                end
            end
            S_IDLE, S_ERASE_SUSP, S_PROG_SUSP: begin
            end
        endcase

        // command writes; outside the setup modes unmatched codes fall through untouched
        if (cmdWrite) begin
            if (mode == M_ERASE_SETUP) begin
                next_mode = M_STATUS;
                if (wb_dat_i != CMD_CONFIRM) begin
                    next_errs.eraseError = 1'b1;
                    next_errs.programError = 1'b1;
                end else if (blockLocked(wb_adr_i[5:4], lockBit, topProtLevel, wpLevel)) begin
                    next_errs.eraseError = 1'b1;
                    next_errs.lockAbort = 1'b1;
                end else begin
                    next_state = S_ERASE;
                    next_eraseBlk = wb_adr_i[5:4];
                    next_eraseIdx = 4'h0;
                    next_eraseCnt = 8'h00;
                end
            end else if (mode == M_PROG_SETUP) begin
                next_mode = M_STATUS;
                if (blockLocked(wb_adr_i[5:4], lockBit, topProtLevel, wpLevel)) begin
                    next_errs.programError = 1'b1;
                    next_errs.lockAbort = 1'b1;
                end else begin
                    next_state = (state == S_ERASE_SUSP) ? S_ESUSP_PROG : S_PROG;
                    next_op = '{addr: wb_adr_i[5:0], data: wb_dat_i};
                    next_progCnt = 8'h00;
                end
            end else if (wb_dat_i == CMD_READ_STATUS) begin
                next_mode = M_STATUS;
            end else if (wb_dat_i == CMD_READ_ARRAY) begin
                if (!running) begin
                    next_mode = M_ARRAY;
                end
            end else if (wb_dat_i == CMD_READ_ID) begin
                if (state == S_IDLE) begin
                    next_mode = M_ID;
                end
            end else if (wb_dat_i == CMD_CLEAR_STATUS) begin
                if (state == S_IDLE) begin
                    next_errs = '0;
                end
            end else if (wb_dat_i == CMD_ERASE_SETUP) begin
                if (state == S_IDLE) begin
                    next_mode = M_ERASE_SETUP;
                end
            end else if (wb_dat_i == CMD_PROG_SETUP) begin
                if (state == S_IDLE || state == S_ERASE_SUSP) begin
                    next_mode = M_PROG_SETUP;
                end
            end else if (wb_dat_i == CMD_SUSPEND) begin
                if (state == S_ERASE) begin
                    next_eraseSuspReq = 1'b1;
                    next_mode = M_STATUS;
                end else if (state == S_PROG) begin
                    next_progSuspReq = 1'b1;
                    next_mode = M_STATUS;
                end
            end else if (wb_dat_i == CMD_CONFIRM) begin
                if (state == S_ERASE_SUSP) begin
                    next_state = S_ERASE;
                    next_mode = M_STATUS;
                end else if (state == S_PROG_SUSP) begin
                    next_state = S_PROG;
                    next_mode = M_STATUS;
                end else if (state == S_ESUSP_PROG) begin
                    next_resumePending = 1'b1;
                    next_mode = M_STATUS;
                end
            end
        end

        // lock registers
        if (take && wb_we_i && wb_sel_i && inLock) begin
            next_lockBit[wb_adr_i[1:0]] = wb_dat_i[`LOCK_WL_BIT];
        end

        // read data captured at the request edge
        if (take && !wb_we_i) begin
            if (inArray) begin
                unique case (mode)
                    M_ARRAY: next_datO = mem[wb_adr_i[5:0]];
                    M_ID: begin
                        if (wb_adr_i[5:0] == `ID_MAKER_ADDR) begin
                            next_datO = MAKER_CODE;
                        end else if (wb_adr_i[5:0] == `ID_PART_ADDR) begin
                            next_datO = PART_CODE;
                        end else begin
                            next_datO = 8'h00;
                        end
                    end
                    M_STATUS, M_ERASE_SETUP, M_PROG_SETUP: next_datO = status;
                endcase
            end else if (inLock) begin
                next_datO = {7'h00, lockBit[wb_adr_i[1:0]]};
            end else begin
                next_datO = 8'h00;
            end
        end

        // init pin behaves as a synchronous reset of control state
        if (!initLevel) begin
            next_mode = M_ARRAY;
            next_state = S_IDLE;
            next_errs = '0;
            next_eraseSuspReq = 1'b0;
            next_progSuspReq = 1'b0;
            next_resumePending = 1'b0;
            next_lockBit = {4{`LOCK_RESET}};
            memWe = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= M_ARRAY;
            state <= S_IDLE;
            op <= '0;
            errs <= '0;
            eraseBlk <= 2'h0;
            eraseIdx <= 4'h0;
            eraseCnt <= 8'h00;
            progCnt <= 8'h00;
            eraseSuspReq <= 1'b0;
            progSuspReq <= 1'b0;
            resumePending <= 1'b0;
            lockBit <= {4{`LOCK_RESET}};
            ack <= 1'b0;
            datO <= 8'h00;
        end else begin
            mode <= next_mode;
            state <= next_state;
            op <= next_op;
            errs <= next_errs;
            eraseBlk <= next_eraseBlk;
            eraseIdx <= next_eraseIdx;
            eraseCnt <= next_eraseCnt;
            progCnt <= next_progCnt;
            eraseSuspReq <= next_eraseSuspReq;
            progSuspReq <= next_progSuspReq;
            resumePending <= next_resumePending;
            lockBit <= next_lockBit;
            ack <= next_ack;
            datO <= next_datO;
        end
    end

    // ******************************
    // array storage
    // ******************************
    // array content survives init; only a full reset erases it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 64; i++) begin
                mem[i] <= `ERASED_BYTE;
            end
        end else if (memWe) begin
            mem[memAddr] <= memData;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = datO;
    assign sequencerReadyFlag = status[`SR_READY];
endmodule // flash_command_state_machine

// *** verification/flash_command_state_machine_assertions.sv ***
// Purpose: bus and status properties of the flash command state machine
// Assumes: classic Wishbone single cycles, ack one cycle after the take edge
// Notes: status mode is tracked only after a status-read write, so other writes just disarm it
`timescale 1ns/100ps
`include "flash_cmd_cfg.svh"
module flash_command_state_machine_assertions
    import flash_cmd_pkg::*;
#(
    parameter logic [7:0] CMD_READ_STATUS = `CMD_READ_STATUS
) (
    input wire logic clk, // clock
    input wire logic rst_n, // async reset, active low
    input wire logic initN, // init pin, active low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic wb_sel_i, // byte select
    input wire logic [7:0] wb_dat_i, // write data
    input wire logic [7:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // acknowledge
    input wire logic sequencerReadyFlag // sequencer not running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic taken;
    logic rTaken;
    logic wTaken;
    logic statusMode;
    logic next_statusMode;
    logic [7:0] busyCnt;
    logic [7:0] next_busyCnt;
    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rTaken = taken && !wb_we_i;
    assign wTaken = taken && wb_we_i;
    always_comb begin
        next_statusMode = statusMode;
        if (!initN) begin
            next_statusMode = 1'b0;
        end else if (wTaken) begin
            next_statusMode = wb_sel_i && wb_dat_i == CMD_READ_STATUS && wb_adr_i <= `ARRAY_LAST;
        end
        // saturate so a hang cannot wrap back under the bound
        next_busyCnt = sequencerReadyFlag ? 8'h00 : (busyCnt == 8'hff ? busyCnt : busyCnt + 8'h01);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            statusMode <= 1'b0;
            busyCnt <= 8'h00;
        end else begin
            statusMode <= next_statusMode;
            busyCnt <= next_busyCnt;
        end
    end
    sequence statusReadTaken;
        rTaken && statusMode && wb_adr_i <= `ARRAY_LAST;
    endsequence
    sequence initHeld;
        !initN [*7];
    endsequence
    a_ack_after_take: assert property (taken |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(taken))
        else $error("ack without a request");
    a_dat_holds: assert property (!$past(rTaken) |-> $stable(wb_dat_o))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (rTaken && wb_adr_i[7:6] == 2'b01 |=> wb_dat_o == 8'h00)
        else $error("unmapped read not zero");
    a_status_bits: assert property (statusReadTaken |=> wb_dat_o[7] == $past(sequencerReadyFlag) && wb_dat_o[3] == 1'b0 && wb_dat_o[0] == 1'b0)
        else $error("status byte disagrees with ready");
    a_busy_bounded: assert property (busyCnt <= 8'h78)
        else $error("sequencer busy too long");
    a_busy_needs_write: assert property ($fell(sequencerReadyFlag) |-> $past(wTaken) || $past(wTaken, 2))
        else $error("sequencer started without a write");
    a_init_readies: assert property (initHeld |-> sequencerReadyFlag)
        else $error("init did not stop the sequencer");
endmodule // flash_command_state_machine_assertions

bind flash_command_state_machine flash_command_state_machine_assertions #(
    .CMD_READ_STATUS(CMD_READ_STATUS)
) chk (.clk, .rst_n, .initN, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .sequencerReadyFlag);

// *** verification/flash_host_model.sv ***
// Purpose: host side bus master issuing command writes and reads
// Assumes: classic Wishbone, one request at a time
// Notes: released lines show inverted data so stale values are never read as valid
`timescale 1ns/100ps
module flash_host_model (
    input wire logic clk, // clock
    input wire logic [7:0] datIn, // read data from device
    input wire logic ackIn, // acknowledge from device
    output logic cyc = 1'b0, // bus cycle
    output logic stb = 1'b0, // strobe
    output logic we = 1'b0, // write enable
    output logic [7:0] adr = 8'h00, // byte address
    output logic sel = 1'b0, // byte select
    output logic [7:0] dat = 8'h00, // write data
    output logic stuck = 1'b0 // ack never came
);
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 1'b1;
        dat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ackIn !== 1'b1 && n < 40);
        q = datIn;
        if (ackIn !== 1'b1) begin
            stuck <= 1'b1;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        adr <= ~a;
        dat <= ~d;
    endtask
endmodule // flash_host_model

// *** verification/flash_command_state_machine_test.sv ***
// Purpose: command sequences against the flash command state machine
// Assumes: default command codes, 40 MHz clock
// Notes: expected status bytes are built from the bit positions
`timescale 1ns/100ps
`include "flash_cmd_cfg.svh"
module flash_command_state_machine_test
    import flash_cmd_pkg::*;
;
    localparam logic [7:0] RDY = 8'h01 << `SR_READY;
    localparam logic [7:0] ESUSP = 8'h01 << `SR_ESUSP;
    localparam logic [7:0] EERR = 8'h01 << `SR_EERR;
    localparam logic [7:0] PERR = 8'h01 << `SR_PERR;
    localparam logic [7:0] PSUSP = 8'h01 << `SR_PSUSP;
    localparam logic [7:0] LOCKB = 8'h01 << `SR_LOCK;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic initN = 1'b1;
    logic topBlockProtectN = 1'b1;
    logic writeProtectN = 1'b1;
    logic cyc, stb, we, sel, ack, stuck, ready;
    logic [7:0] adr, datW, datR, s;
    int nErrors = 0;
    int checks = 0;
    always #12.5 clk = ~clk;
    flash_host_model host (.clk(clk), .datIn(datR), .ackIn(ack), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .sel(sel), .dat(datW), .stuck(stuck));
    flash_command_state_machine DUT (.clk(clk), .rst_n(rst_n), .initN(initN),
        .topBlockProtectN(topBlockProtectN), .writeProtectN(writeProtectN), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
        .sequencerReadyFlag(ready));
    task automatic wrap_up;
        if (nErrors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.access(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] q;
        host.access(1'b0, a, 8'h00, q);
        chk(what, exp, q);
    endtask
    // status polling is bounded; a sequencer that never finishes fails the run
    task automatic poll(output logic [7:0] st);
        int n;
        n = 0;
        do begin
            host.access(1'b0, 8'h00, 8'h00, st);
            n++;
        end while (st[7] !== 1'b1 && n < 100);
        if (st[7] !== 1'b1) begin
            nErrors++;
            wrap_up();
        end
    endtask
    always @(posedge stuck) begin
        nErrors++;
        wrap_up();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rdc(8'h00, `ERASED_BYTE, "array after reset");
        rdc(8'h80, 8'h01, "lock reset");
        wr(8'h00, `CMD_READ_ID);
        rdc(8'h00, `ID_MAKER_CODE, "maker code");
        rdc(8'h01, `ID_PART_CODE, "part code");
        rdc(8'h00, `ID_MAKER_CODE, "maker code again");
        wr(8'h00, `CMD_READ_ARRAY);
        rdc(8'h01, `ERASED_BYTE, "array after id");
        wr(8'h00, `CMD_PROG_SETUP);
        wr(8'h05, 8'ha5);
        poll(s);
        chk("locked program status", RDY | LOCKB, s & (RDY | LOCKB));
        wr(8'h00, `CMD_READ_ARRAY);
        rdc(8'h05, `ERASED_BYTE, "locked byte");
        wr(8'h00, `CMD_CLEAR_STATUS);
        wr(8'h00, `CMD_READ_STATUS);
        rdc(8'h00, RDY, "cleared status");
        wr(8'h80, 8'h00);
        wr(8'h81, 8'h00);
        wr(8'h83, 8'h00);
        rdc(8'h80, 8'h00, "unlocked");
        wr(8'h00, `CMD_PROG_SETUP);
        wr(8'h05, 8'ha5);
        rdc(8'h00, 8'h00, "busy status");
        poll(s);
        chk("program status", RDY, s);
        chk("ready pin", 8'h01, {7'h00, ready});
        rdc(8'h00, RDY, "status persists");
        wr(8'h00, `CMD_PROG_SETUP);
        wr(8'h05, 8'h0f);
        poll(s);
        chk("zero bits kept status", RDY, s);
        wr(8'h00, `CMD_PROG_SETUP);
        wr(8'h06, 8'h3c);
        wr(8'h00, `CMD_READ_ARRAY);
        rdc(8'h00, 8'h00, "array read while busy");
        poll(s);
        wr(8'h00, `CMD_READ_ARRAY);
        rdc(8'h05, 8'h05, "and of programs");
        rdc(8'h06, 8'h3c, "second byte");
        topBlockProtectN <= 1'b0;
        wr(8'h00, `CMD_ERASE_SETUP);
        wr(8'h35, `CMD_CONFIRM);
        poll(s);
        chk("protected erase", RDY | EERR | LOCKB, s & (RDY | EERR | LOCKB));
        topBlockProtectN <= 1'b1;
        wr(8'h00, `CMD_CLEAR_STATUS);
        wr(8'h00, `CMD_ERASE_SETUP);
        wr(8'h00, 8'h33);
        poll(s);
        chk("bad sequence", RDY | EERR | PERR, s);
        wr(8'h00, `CMD_CLEAR_STATUS);
        wr(8'h00, `CMD_ERASE_SETUP);
        wr(8'h0c, `CMD_CONFIRM);
        rdc(8'h00, 8'h00, "erase busy");
        wr(8'h00, `CMD_SUSPEND);
        poll(s);
        chk("erase suspended", RDY | ESUSP, s);
        wr(8'h00, `CMD_READ_ARRAY);
        rdc(8'h10, `ERASED_BYTE, "other block");
        wr(8'h00, `CMD_PROG_SETUP);
        wr(8'h11, 8'h12);
        wr(8'h00, `CMD_CONFIRM);
        poll(s);
        chk("erase resumed done", RDY, s);
        wr(8'h00, `CMD_READ_ARRAY);
        rdc(8'h11, 8'h12, "program in suspend");
        for (int i = 0; i < 16; i++) begin
            rdc(8'(i), `ERASED_BYTE, "erased byte");
        end
        wr(8'h00, `CMD_PROG_SETUP);
        wr(8'h07, 8'h5a);
        wr(8'h00, `CMD_SUSPEND);
        poll(s);
        chk("program suspended", RDY | PSUSP, s);
        wr(8'h00, `CMD_READ_ARRAY);
        rdc(8'h08, `ERASED_BYTE, "read in program suspend");
        wr(8'h00, `CMD_READ_ID);
        rdc(8'h01, `ERASED_BYTE, "id refused in suspend");
        wr(8'h00, `CMD_READ_STATUS);
        rdc(8'h00, RDY | PSUSP, "status in suspend");
        wr(8'h00, `CMD_CONFIRM);
        poll(s);
        wr(8'h00, `CMD_READ_ARRAY);
        rdc(8'h07, 8'h5a, "resumed program");
        wr(8'h00, 8'h12);
        rdc(8'h07, 8'h5a, "unknown command");
        wr(8'h00, `CMD_ERASE_SETUP);
        wr(8'h00, `CMD_CONFIRM);
        // init only after every suspend has ended
        initN <= 1'b0;
        repeat (8) @(posedge clk);
        initN <= 1'b1;
        repeat (6) @(posedge clk);
        rdc(8'h20, `ERASED_BYTE, "array after init");
        rdc(8'h80, 8'h01, "lock after init");
        rdc(8'h40, 8'h00, "unmapped");
        wrap_up();
    end
endmodule // flash_command_state_machine_test
